// file: bench/pio_far_model.sv
// far side of port 4: pull-ups and can transceiver receive levels
// assumes the drive struct of the port block, no clock needed
`timescale 1ns/10ps
module pio_far_model
  import pio_pkg::*;
(
  // block drive and transceiver levels
  input  pio_drv_s   i_drv,
  input  wire logic  i_rx_a,
  input  wire logic  i_rx_b,
  // resolved pin levels
  output logic [7:0] o_pin
);
  // released lines go to the pull-up, rx lines to the transceiver
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      o_pin[i] = i_drv.oe[i] ? i_drv.out[i] : (i == 4) ? i_rx_b : (i == 5) ? i_rx_a : 1'h1;
    end
  end
endmodule

// file: bench/pio_monitor.sv
// concurrent checks on the apb answer and port 4 drive of pio_top
// assumes it is bound to pio_top and sees only its ports
`timescale 1ns/10ps
module pio_monitor
  import pio_pkg::*;
(
  // clock, reset, apb
  input wire logic              i_ref_clk,
  input wire logic              i_reset_n,
  input wire logic              i_psel,
  input wire logic              i_penable,
  input wire logic              i_pwrite,
  input wire logic [APB_AW-1:0] i_paddr,
  input wire logic              o_pready,
  input wire logic [31:0]       o_prdata,
  input wire logic              o_pslverr,
  // strap and port 4
  input wire logic [15:0]       i_multiplexed_bus_port_zero,
  input wire logic [7:0]        i_seg_addr,
  input pio_drv_s               o_port4
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  logic [1:0]  sel_r;
  logic        first_r;
  logic [1:0]  up_r;
  logic [7:0]  mask;
  wire  [15:0] idx    = i_paddr[APB_AW-1:2];
  wire         setup  = i_psel && !i_penable;
  wire         rd_acc = o_pready && i_psel && i_penable && !i_pwrite;
  // strap copy, taken once at the first edge after release
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sel_r   <= SEG_NONE;
      first_r <= 1'h1;
    end else if (first_r) begin
      sel_r   <= i_multiplexed_bus_port_zero[SEG_SEL_LSB+:2];
      first_r <= 1'h0;
    end
  end
  // edges since release; drive is trusted only once settled
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  end
  // lines owned by the segment address
  always_comb begin
    case (sel_r)
      SEG_A17: mask = 8'h03;
      SEG_A19: mask = 8'h0f;
      SEG_A23: mask = 8'hff;
      default: mask = 8'h00;
    endcase
  end
  property p_rdy_next; setup |=> o_pready ##1 !o_pready; endproperty
  a_rdy_next: assert property (p_rdy_next) else $error("pready not one cycle after setup");
  property p_rdy_src; o_pready |-> $past(setup); endproperty
  a_rdy_src: assert property (p_rdy_src) else $error("pready without setup");
  property p_err; o_pslverr |-> o_pready; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_idle; !o_pready |-> o_prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("prdata not zero when idle");
  property p_od; rd_acc && idx == IDX_P4_OD |-> (o_prdata & ~32'hc0) == 32'h0; endproperty
  a_od: assert property (p_od) else $error("port 4 od reads extra bits");
  property p_cfg; rd_acc && idx == IDX_RST_CFG |-> o_prdata[12:11] == sel_r; endproperty
  a_cfg: assert property (p_cfg) else $error("strap field wrong");
  property p_seg; up_r == 2'h3 |-> (o_port4.oe & mask) == mask && (o_port4.out & mask) == ($past(i_seg_addr) & mask);
  endproperty
  a_seg: assert property (p_seg) else $error("segment drive wrong");
  property p_p5w; o_pready && i_pwrite && idx == IDX_P5_DATA |-> !o_pslverr; endproperty
  a_p5w: assert property (p_p5w) else $error("port 5 write refused");
  c_wr: cover property (o_pready && i_pwrite);
  c_err: cover property (o_pslverr);
  c_a23: cover property (up_r == 2'h3 && mask == 8'hff);
endmodule
bind pio_top pio_monitor pio_monitor_inst (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_pready(o_pready), .o_prdata(o_prdata),
  .o_pslverr(o_pslverr), .i_multiplexed_bus_port_zero(i_multiplexed_bus_port_zero), .i_seg_addr(i_seg_addr),
  .o_port4(o_port4));

// file: bench/tb_port4_port5_port6_io.sv
// self-checking bench for pio_top: register table, pin drive, strap codes
// assumes the far side model on port 4 and the bound monitor
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("Error %s exp %h got %h", nm, e, g); end end
module tb_port4_port5_port6_io
  import pio_pkg::*;
();
  logic        clk = 1'h0, rst_n = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
  logic        txa_en = 1'h0, txb_en = 1'h0, txa = 1'h0, txb = 1'h0, rxa = 1'h1, rxb = 1'h1;
  logic        rdy, err, cra, crb, e;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] p0 = 16'h0800, p5 = 16'h0;
  logic [7:0]  seg = 8'h0, p4pin, p6pin = 8'h0;
  logic [3:0]  pstrb = 4'hf;
  pio_drv_s    p4, p6;
  pio_tmr_s    tmr;
  int          n_errors = 0, check_count = 0, cyc = 0;
  logic [15:0] t_idx [7] = '{IDX_P4_LATCH, IDX_P4_DIR, IDX_P4_OD, IDX_P6_LATCH, IDX_P6_DIR, IDX_P6_OD, IDX_P5_DIS};
  logic [15:0] t_wd [7]  = '{16'h5aa5, 16'h003c, 16'h33ff, 16'h005a, 16'h00f0, 16'h000f, 16'h8421};
  logic [15:0] t_ex [7]  = '{16'h00a5, 16'h003c, 16'h00c0, 16'h005a, 16'h00f0, 16'h000f, 16'h8421};
  logic [1:0]  s_code [4] = '{SEG_NONE, SEG_A17, SEG_A19, SEG_A23};
  logic [7:0]  s_mask [4] = '{8'h00, 8'h03, 8'h0f, 8'hff};
  pio_top pio_top_inst (.i_ref_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_pready(rdy), .o_prdata(prdata), .o_pslverr(err),
    .i_multiplexed_bus_port_zero(p0), .i_port4_pin(p4pin), .o_port4(p4), .i_seg_addr(seg),
    .i_can_a_tx_en(txa_en), .i_can_b_tx_en(txb_en), .i_can_a_transmit(txa), .i_can_b_transmit(txb),
    .o_can_a_receive(cra), .o_can_b_receive(crb), .i_port5_pin(p5), .o_timer_ctl(tmr),
    .i_port6_pin(p6pin), .o_port6(p6));
  pio_far_model pio_far_model_inst (.i_drv(p4), .i_rx_a(rxa), .i_rx_b(rxb), .o_pin(p4pin));
  // 250 MHz clock
  always #2 clk = ~clk;
  // hang guard, far above the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [15:0] ix, input logic [31:0] d, output logic [31:0] q,
                     output logic se);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'h1;
    pen    <= 1'h0;
    pwr    <= w;
    paddr  <= {ix, 2'h0};
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    // pready, read data and error are taken at the rising edge only
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'h1 && n < 50);
    if (rdy !== 1'h1) n_errors++;
    q  = prdata;
    se = err;
    psel <= 1'h0;
    pen  <= 1'h0;
  endtask
  task automatic wr(input logic [15:0] ix, input logic [31:0] d);
    apb(1'h1, ix, d, rd, e);
  endtask
  task automatic rdchk(input string nm, input logic [15:0] ix, input logic [31:0] ex);
    apb(1'h0, ix, 32'h0, rd, e);
    `CHK(nm, ex, rd)
  endtask
  // pin drive lags the write; look once it has landed
  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic do_reset(input logic [1:0] code);
    @(posedge clk);
    rst_n <= 1'h0;
    p0    <= {3'h0, code, 11'h0};
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
  endtask
  initial begin
    do_reset(SEG_NONE);
    for (int i = 0; i < 7; i++) rdchk("reset", t_idx[i], 32'h0);
    // table rows: write with junk in upper lanes, read back masked
    for (int i = 0; i < 7; i++) begin
      wr(t_idx[i], {16'hffff, t_wd[i]});
      rdchk("table", t_idx[i], {16'h0, t_ex[i]});
    end
    settle();
    `CHK("p4 oe", 8'h3c, p4.oe)
    `CHK("p4 out", 8'h24, p4.out & p4.oe)
    `CHK("p6 oe", 8'hf0, p6.oe)
    `CHK("p6 out", 8'h50, p6.out & p6.oe)
    wr(IDX_P6_DIR, 32'hff);
    settle();
    `CHK("p6 od oe", 8'hf5, p6.oe)
    `CHK("p6 od out", 8'h50, p6.out)
    wr(IDX_P4_DIR, 32'hc0);
    wr(IDX_P4_LATCH, 32'h40);
    settle();
    `CHK("p4 od oe", 8'h80, p4.oe)
    `CHK("p4 od out", 8'h00, p4.out)
    wr(IDX_P4_OD, 32'h0);
    txa_en <= 1'h1;
    txb_en <= 1'h1;
    txb    <= 1'h1;
    rxa    <= 1'h0;
    settle();
    `CHK("can tx oe", 8'hc0, p4.oe & 8'hc0)
    `CHK("can tx out", 8'h80, p4.out & 8'hc0)
    `CHK("can a rx", 1'h0, cra)
    `CHK("can b rx", 1'h1, crb)
    @(posedge clk);
    p5     <= 16'ha53c;
    txa_en <= 1'h0;
    txb_en <= 1'h0;
    wr(IDX_P5_DIS, 32'h0);
    wr(IDX_P5_DATA, 32'hffff);
    rdchk("p5 pins", IDX_P5_DATA, 32'ha53c);
    `CHK("timers", 6'h25, tmr)
    wr(IDX_P5_DIS, 32'h0c0f);
    rdchk("p5 dis", IDX_P5_DATA, 32'ha130);
    settle();
    `CHK("timers dis", 6'h05, tmr)
    apb(1'h0, 16'h0, 32'h0, rd, e);
    `CHK("unmapped", 33'h100000000, {e, rd})
    // every strap code after a fresh reset
    for (int k = 0; k < 4; k++) begin
      do_reset(s_code[k]);
      seg <= 8'h9c;
      settle();
      `CHK("seg boot", s_mask[k], p4.oe)
      wr(IDX_P4_OD, 32'hc0);
      wr(IDX_P4_LATCH, 32'hc0);
      wr(IDX_P4_DIR, 32'hff);
      settle();
      `CHK("seg oe", s_mask[k] | 8'h3f, p4.oe)
      `CHK("seg out", s_mask[k] & 8'h9c, p4.out)
      `CHK("seg rx", s_mask[k][7], cra)
      apb(1'h0, IDX_RST_CFG, 32'h0, rd, e);
      `CHK("cfg", s_code[k], rd[12:11])
    end
    print_verdict();
  end
endmodule

// file: core/pio_pkg.sv
// constants and types for the port 4/5/6 i/o block
// assumes an apb master on the cpu clock and pins sampled synchronously
// Overview of operation
// (RQ1) a port 4 line is a high-impedance input with direction 0 and drives its latch with direction 1.
// (RQ2) a port 4 line with its open-drain bit set drives open-drain unless it is a segment address line.
// (RQ3) only bits 6 and 7 of the port 4 open-drain register exist and all other bits read zero.
// (RQ4) port 4 takes up the segment address function by itself after reset when address lines are selected.
// (RQ5) selection 01 gives no address lines, 11 gives a16-a17, 00 gives a16-a19 and 10 gives a16-a23.
// (RQ6) the selection is taken from port 0 at reset and stays readable in a read-only field.
// (RQ7) port 4 lines 4 to 7 carry can b receive, can a receive, can a transmit and can b transmit.
// (RQ8) port 5 is a 16-bit input-only port and writes to its data register are dropped.
// (RQ9) reading the port 5 data register returns the present pin levels.
// (RQ10) port 5 lines 10 to 15 feed the timer 6/5 up-down, timer 6/5 count and timer 4/2 up-down inputs.
// (RQ11) each port 5 line has a digital-input disable bit, 0 enabling and 1 disabling the path.
// (RQ12) a port 6 line is a high-impedance input with direction 0 and drives its latch with direction 1.
// (RQ13) each port 6 line picks push-pull or open-drain output through its own open-drain bit.
// (RQ14) a port 4 segment address line drives the address whatever its latch and direction bits say.
// (RQ15) a port 5 line with its digital input disabled presents a constant zero instead of the pin.
package pio_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_P5_DATA   = 16'hffa2;
  localparam logic [15:0] IDX_P5_DIS    = 16'hffa4;
  localparam logic [15:0] IDX_P4_LATCH  = 16'hffc8;
  localparam logic [15:0] IDX_P4_DIR    = 16'hffca;
  localparam logic [15:0] IDX_P6_LATCH  = 16'hffcc;
  localparam logic [15:0] IDX_P6_DIR    = 16'hffce;
  localparam logic [15:0] IDX_P4_OD     = 16'hf1ca;
  localparam logic [15:0] IDX_P6_OD     = 16'hf1ce;
  localparam logic [15:0] IDX_RST_CFG   = 16'hf100;

  localparam int unsigned APB_AW = 18;

  // reset values
  localparam logic [7:0]  RST_P4_LATCH = 8'h00;
  localparam logic [7:0]  RST_P4_DIR   = 8'h00;
  localparam logic [7:0]  RST_P4_OD    = 8'h00;
  localparam logic [15:0] RST_P5_DIS   = 16'h0000;
  localparam logic [7:0]  RST_P6_LATCH = 8'h00;
  localparam logic [7:0]  RST_P6_DIR   = 8'h00;
  localparam logic [7:0]  RST_P6_OD    = 8'h00;
  localparam logic [15:0] RST_P5_DATA  = 16'h0000;
  localparam logic        RST_CAN_RX   = 1'b1;

  // implemented bits of the port 4 open-drain register
  localparam logic [7:0]  P4_OD_MASK   = 8'hc0;

  // segment line selection codes and their place in port 0 / config reg
  localparam logic [1:0]  SEG_NONE     = 2'b01;
  localparam logic [1:0]  SEG_A17      = 2'b11;
  localparam logic [1:0]  SEG_A19      = 2'b00;
  localparam logic [1:0]  SEG_A23      = 2'b10;
  localparam int unsigned SEG_SEL_LSB  = 11;
  localparam int unsigned CFG_SEL_LSB  = 11;

  // port 4 can line positions
  localparam int unsigned P4_CANB_RX = 4;
  localparam int unsigned P4_CANA_RX = 5;
  localparam int unsigned P4_CANA_TX = 6;
  localparam int unsigned P4_CANB_TX = 7;

  // level shown by a disabled port 5 input
  localparam logic        P5_DIS_LEVEL = 1'b0;

  // drive of an 8-bit port: pin value and output enable
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pio_drv_s;

  // timer control inputs fed from port 5
  typedef struct packed {
    logic t6_updown;
    logic t5_updown;
    logic t6_count;
    logic t5_count;
    logic t4_updown;
    logic t2_updown;
  } pio_tmr_s;

endpackage

// file: core/pio_top.sv
// port 4, 5 and 6 general purpose i/o with apb register access
// assumes pins and peripheral inputs are synchronous to i_ref_clk
`timescale 1ns/10ps
module pio_top
  import pio_pkg::*;
(
  // clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_reset_n,
  // apb slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [APB_AW-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  input  wire logic [3:0]        i_pstrb,
  output logic                   o_pready,
  output logic [31:0]            o_prdata,
  output logic                   o_pslverr,
  // reset configuration from port 0
  input  wire logic [15:0]       i_multiplexed_bus_port_zero,
  // port 4 pins and alternate sources
  input  wire logic [7:0]        i_port4_pin,
  output pio_drv_s               o_port4,
  input  wire logic [7:0]        i_seg_addr,
  input  wire logic              i_can_a_tx_en,
  input  wire logic              i_can_b_tx_en,
  input  wire logic              i_can_a_transmit,
  input  wire logic              i_can_b_transmit,
  output logic                   o_can_a_receive,
  output logic                   o_can_b_receive,
  // port 5 pins and timer inputs
  input  wire logic [15:0]       i_port5_pin,
  output pio_tmr_s               o_timer_ctl,
  // port 6 pins
  input  wire logic [7:0]        i_port6_pin,
  output pio_drv_s               o_port6
);

  // byte-lane merge for the 16-bit port 5 disable register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) begin
      r[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // lane 0 merge for the 8-bit registers; upper lanes have no bits here
  function automatic logic [7:0] merge8(input logic [7:0]  old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  strb);
    logic [7:0] r;
    r = old;
    if (strb[0]) begin
      r = wd[7:0];
    end
    return r;
  endfunction

  // one open-drain or push-pull line: returns {oe, out}
  function automatic logic [1:0] drive(input logic val,
                                       input logic en,
                                       input logic od);
    logic [1:0] r;
    r = 2'b00;
    if (en && od) begin
      r = {~val, 1'b0};
    end else if (en) begin
      r = {1'b1, val};
    end
    return r;
  endfunction

  // mask of segment address lines for a selection code
  function automatic logic [7:0] seg_mask(input logic [1:0] sel);
    logic [7:0] m;
    m = 8'h00;
    case (sel)
      SEG_NONE: m = 8'h00;
      SEG_A17:  m = 8'h03;
      SEG_A19:  m = 8'h0f;
      SEG_A23:  m = 8'hff;
      default:  m = 8'h00;
    endcase
    return m;
  endfunction

  // register state
  logic [7:0]  p4_latch_r;
  logic [7:0]  p4_dir_r;
  logic [7:0]  p4_od_r;
  logic [15:0] p5_dis_r;
  logic [15:0] p5_data_r;
  logic [7:0]  p6_latch_r;
  logic [7:0]  p6_dir_r;
  logic [7:0]  p6_od_r;
  logic [1:0]  seg_sel_r;
  logic        cfg_taken_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;
  pio_drv_s    port4_r;
  pio_drv_s    port6_r;
  pio_drv_s    port4_nxt;
  pio_drv_s    port6_nxt;
  pio_tmr_s    tmr_r;
  logic        cana_rx_r;
  logic        canb_rx_r;

  // bus decode
  logic [15:0] idx;
  logic        setup;
  logic        wr_go;
  logic        hit;
  logic [31:0] rd_nxt;

  assign idx   = i_paddr[APB_AW-1:2];
  assign setup = i_psel && !i_penable;
  assign wr_go = i_psel && i_penable && i_pwrite && pready_r;

  // lines owned by the latched selection, shared by drive and can taps
  logic [7:0]  seg_lines;
  assign seg_lines = seg_mask(seg_sel_r);

  // read mux; unmapped index gives zero data and an error
  always_comb begin
    hit    = 1'b1;
    rd_nxt = 32'h0000_0000;
    case (idx)
      IDX_P4_LATCH: rd_nxt[7:0]  = p4_latch_r;
      IDX_P4_DIR:   rd_nxt[7:0]  = p4_dir_r;
      // (RQ3) unbuilt bits read zero
      IDX_P4_OD:    rd_nxt[7:0]  = p4_od_r & P4_OD_MASK;
      // (RQ9) live pin levels
      IDX_P5_DATA:  rd_nxt[15:0] = p5_data_r;
      IDX_P5_DIS:   rd_nxt[15:0] = p5_dis_r;
      IDX_P6_LATCH: rd_nxt[7:0]  = p6_latch_r;
      IDX_P6_DIR:   rd_nxt[7:0]  = p6_dir_r;
      IDX_P6_OD:    rd_nxt[7:0]  = p6_od_r;
      // (RQ6) read-only selection field
      IDX_RST_CFG:  rd_nxt[CFG_SEL_LSB +: 2] = seg_sel_r;
      default:      hit = 1'b0;
    endcase
  end

  // zero-wait answer: data is fetched in setup, shown in access
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup && !hit;
      prdata_r  <= (setup && !i_pwrite) ? rd_nxt : 32'h0000_0000;
    end
  end

  // port 4 registers
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      p4_latch_r <= RST_P4_LATCH;
      p4_dir_r   <= RST_P4_DIR;
      p4_od_r    <= RST_P4_OD;
    end else if (wr_go) begin
      if (idx == IDX_P4_LATCH) begin
        p4_latch_r <= merge8(p4_latch_r, i_pwdata, i_pstrb);
      end
      if (idx == IDX_P4_DIR) begin
        p4_dir_r <= merge8(p4_dir_r, i_pwdata, i_pstrb);
      end
      // (RQ3) only bits 6 and 7 kept
      if (idx == IDX_P4_OD) begin
        p4_od_r <= merge8(p4_od_r, i_pwdata, i_pstrb) & P4_OD_MASK;
      end
    end
  end

  // port 5 disable register; the data index has no write path
  // (RQ8) data writes dropped
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      p5_dis_r <= RST_P5_DIS;
    end else if (wr_go && idx == IDX_P5_DIS) begin
      p5_dis_r <= merge16(p5_dis_r, i_pwdata, i_pstrb);
    end
  end

  // port 6 registers
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      p6_latch_r <= RST_P6_LATCH;
      p6_dir_r   <= RST_P6_DIR;
      p6_od_r    <= RST_P6_OD;
    end else if (wr_go) begin
      if (idx == IDX_P6_LATCH) begin
        p6_latch_r <= merge8(p6_latch_r, i_pwdata, i_pstrb);
      end
      if (idx == IDX_P6_DIR) begin
        p6_dir_r <= merge8(p6_dir_r, i_pwdata, i_pstrb);
      end
      if (idx == IDX_P6_OD) begin
        p6_od_r <= merge8(p6_od_r, i_pwdata, i_pstrb);
      end
    end
  end

  // strap capture on the first edge after release; async reset
  // may only load constants, so port 0 is read here instead
  // (RQ6) latch port 0 once
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfg_taken_r <= 1'b0;
      seg_sel_r   <= SEG_NONE;
    end else if (!cfg_taken_r) begin
      cfg_taken_r <= 1'b1;
      seg_sel_r   <= i_multiplexed_bus_port_zero[SEG_SEL_LSB +: 2];
    end
  end

  // port 4 pin drive
  always_comb begin
    logic [7:0] seg;
    logic [7:0] val;
    logic [7:0] en;
    logic [7:0] od;
    logic [1:0] d;
    seg = 8'h00;
    val = 8'h00;
    en  = 8'h00;
    od  = 8'h00;
    d   = 2'b00;
    port4_nxt = '0;
    // (RQ5) lines taken by the selection
    seg = seg_lines;
    // (RQ1) latch and direction
    val = p4_latch_r;
    en  = p4_dir_r;
    od  = p4_od_r;
    // (RQ7) can transmit on lines 6 and 7
    if (i_can_a_tx_en) begin
      val[P4_CANA_TX] = i_can_a_transmit;
      en[P4_CANA_TX]  = 1'b1;
    end
    if (i_can_b_tx_en) begin
      val[P4_CANB_TX] = i_can_b_transmit;
      en[P4_CANB_TX]  = 1'b1;
    end
    // (RQ4) segment function without setup
    // (RQ14) address overrides latch and direction
    val = (val & ~seg) | (i_seg_addr & seg);
    en  = en | seg;
    // (RQ2) open-drain except on address lines
    od  = od & ~seg;
    for (int i = 0; i < 8; i++) begin
      d = drive(val[i], en[i], od[i]);
      port4_nxt.oe[i]  = d[1];
      port4_nxt.out[i] = d[0];
    end
  end

  // port 6 pin drive
  always_comb begin
    logic [1:0] d;
    d = 2'b00;
    port6_nxt = '0;
    // (RQ12) latch and direction
    // (RQ13) per-line open-drain choice
    for (int i = 0; i < 8; i++) begin
      d = drive(p6_latch_r[i], p6_dir_r[i], p6_od_r[i]);
      port6_nxt.oe[i]  = d[1];
      port6_nxt.out[i] = d[0];
    end
  end

  // registered pin drivers
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      port4_r <= '0;
      port6_r <= '0;
    end else begin
      port4_r <= port4_nxt;
      port6_r <= port6_nxt;
    end
  end

  // can receive taps; an address line hides the pin from can
  // (RQ7) receive on lines 4 and 5
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cana_rx_r <= RST_CAN_RX;
      canb_rx_r <= RST_CAN_RX;
    end else begin
      cana_rx_r <= seg_lines[P4_CANA_RX] ? 1'b1 : i_port4_pin[P4_CANA_RX];
      canb_rx_r <= seg_lines[P4_CANB_RX] ? 1'b1 : i_port4_pin[P4_CANB_RX];
    end
  end

  // port 5 digital path; disabling saves leakage, so the
  // reading is a fixed level rather than the floating pin
  // (RQ11) per-line disable
  // (RQ15) constant level when disabled
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      p5_data_r <= RST_P5_DATA;
    end else begin
      for (int i = 0; i < 16; i++) begin
        p5_data_r[i] <= p5_dis_r[i] ? P5_DIS_LEVEL : i_port5_pin[i];
      end
    end
  end

  // timer inputs follow the filtered port 5 lines
  // (RQ10) lines 10 to 15
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tmr_r <= '0;
    end else begin
      tmr_r.t6_updown <= p5_dis_r[10] ? P5_DIS_LEVEL : i_port5_pin[10];
      tmr_r.t5_updown <= p5_dis_r[11] ? P5_DIS_LEVEL : i_port5_pin[11];
      tmr_r.t6_count  <= p5_dis_r[12] ? P5_DIS_LEVEL : i_port5_pin[12];
      tmr_r.t5_count  <= p5_dis_r[13] ? P5_DIS_LEVEL : i_port5_pin[13];
      tmr_r.t4_updown <= p5_dis_r[14] ? P5_DIS_LEVEL : i_port5_pin[14];
      tmr_r.t2_updown <= p5_dis_r[15] ? P5_DIS_LEVEL : i_port5_pin[15];
    end
  end

  // outputs straight from flops
  assign o_pready        = pready_r;
  assign o_prdata        = prdata_r;
  assign o_pslverr       = pslverr_r;
  assign o_port4         = port4_r;
  assign o_port6         = port6_r;
  assign o_timer_ctl     = tmr_r;
  assign o_can_a_receive = cana_rx_r;
  assign o_can_b_receive = canb_rx_r;

  // port 6 pins are not read back; kept for the alternate functions
  logic unused_p6;
  assign unused_p6 = ^i_port6_pin;

endmodule
